// ==== core/rpm_top.sv ====
// Purpose: slave command handling for a two-output bias controller on a two-wire front-end bus
// Assumes: bus clock well below CLK_I/4; SCLK_I, SDATA_I, SLAVE_ADDR_I are asynchronous
// Notes:   master drives on SCLK rise, slave samples on SCLK fall; odd parity on every frame
`timescale 1ns/1ps
`include "rpm_defines.svh"

module rpm_top (
	input  wire logic              CLK_I,
	input  wire logic              RESETN_I,
	input  wire logic              SCLK_I,
	input  wire logic              SDATA_I,
	input  wire logic [3:0]        SLAVE_ADDR_I,
	output logic                   SDATA_O,
	output logic                   SDATA_OE_O,
	output rpm_pkg::rpm_pstate_t   POWER_STATE_O,
	output logic                   BOOST_EN_O,
	output logic                   OUT_A_EN_O,
	output logic                   OUT_B_EN_O,
	output logic                   LOW_POWER_O,
	output rpm_pkg::rpm_byte_t     TURBO_O,
	output rpm_pkg::rpm_byte_t     DAC_A_O,
	output rpm_pkg::rpm_byte_t     DAC_B_O,
	output rpm_pkg::rpm_byte_t     STATUS_O
);
	import rpm_pkg::*;

	// odd parity: frame plus its parity bit holds an odd count of ones
	function automatic logic odd_ok(input logic [12:0] v);
		odd_ok = ^v;
	endfunction : odd_ok

	logic [2:0]  sclk_reg,  sclk_next;
	logic [2:0]  sdata_reg, sdata_next;
	logic [3:0]  own_m_reg, own_m_next;
	logic [3:0]  own_reg,   own_next;
	logic        sclk_rise, sclk_fall, sdata_rise, sdata_fall, ssc;

	// two-stage synchronisers plus one stage for edge finding
	always_comb
	begin
		sclk_next  = {sclk_reg[1:0], SCLK_I};
		sdata_next = {sdata_reg[1:0], SDATA_I};
		own_m_next = SLAVE_ADDR_I;
		own_next   = own_m_reg;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			sclk_reg  <= 3'h0;
			sdata_reg <= 3'h0;
			own_m_reg <= 4'h0;
			own_reg   <= 4'h0;
		end
		else
		begin
			sclk_reg  <= sclk_next;
			sdata_reg <= sdata_next;
			own_m_reg <= own_m_next;
			own_reg   <= own_next;
		end
	end

	// only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
	assign sclk_rise  = sclk_reg[1] & ~sclk_reg[2];
	assign sclk_fall  = ~sclk_reg[1] & sclk_reg[2];
	assign sdata_rise = sdata_reg[1] & ~sdata_reg[2];
	assign sdata_fall = ~sdata_reg[1] & sdata_reg[2];

	rpm_state_e  state_reg, state_next;
	logic [3:0]  cnt_reg,   cnt_next;
	logic [12:0] sh_reg,    sh_next;
	logic [7:0]  addr_reg,  addr_next;
	logic [3:0]  left_reg,  left_next;
	logic [6:0]  flag_reg,  flag_next;
	logic        arm_reg,   arm_next;
	logic        sdo_reg,   sdo_next;
	logic        sdoe_reg,  sdoe_next;
	rpm_pstate_t pst_reg,   pst_next;
	rpm_byte_t   turbo_reg, turbo_next;
	rpm_byte_t   daca_reg,  daca_next;
	rpm_byte_t   dacb_reg,  dacb_next;
	logic [12:0] bits;
	logic [6:0]  set;
	logic        clr, wr_en;
	rpm_byte_t   wr_data;

	// sequence start: data rises then falls while the bus clock stays low
	assign ssc = arm_reg & ~sclk_reg[1] & sdata_fall & ~sdoe_reg;

	// frame decoding, register writes, read-back and status flags
	always_comb
	begin
		bits       = {sh_reg[11:0], sdata_reg[1]};
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		addr_next  = addr_reg;
		left_next  = left_reg;
		arm_next   = arm_reg;
		sdo_next   = sdo_reg;
		sdoe_next  = sdoe_reg;
		pst_next   = pst_reg;
		turbo_next = turbo_reg;
		daca_next  = daca_reg;
		dacb_next  = dacb_reg;
		set        = 7'h00;
		clr        = 1'b0;
		wr_en      = 1'b0;
		wr_data    = bits[8:1];
		if (sclk_rise)
			arm_next = 1'b0;
		else if (!sclk_reg[1] && sdata_rise && !sdoe_reg)
			arm_next = 1'b1;
		if (ssc)
		begin
			// a start inside a sequence means it was cut short
			if (state_reg == ST_CMD)
				set[`RPM_F_BUS_ERR] = 1'b1;
			else if (state_reg != ST_IDLE)
				set[`RPM_F_CMD_LEN] = 1'b1;
			state_next = ST_CMD;
			cnt_next   = 4'h0;
			sdoe_next  = 1'b0;
			arm_next   = 1'b0;
		end
		else if (sclk_fall)
		begin
			cnt_next = cnt_reg + 4'h1;
			sh_next  = bits;
			case (state_reg)
				ST_CMD:
					if (cnt_reg == `RPM_CMD_LAST)
					begin
						state_next = ST_IDLE;
						cnt_next   = 4'h0;
						if (bits[12:9] != own_reg)
							state_next = ST_IDLE;
						else if (!odd_ok(bits))
							set[`RPM_F_CMD_PAR] = 1'b1;
						else if (bits[8:6] == `RPM_OP_WRITE)
						begin
							addr_next  = {3'h0, bits[5:1]};
							left_next  = 4'h0;
							state_next = ST_DATA;
						end
						else if (bits[8:6] == `RPM_OP_READ)
						begin
							addr_next  = {3'h0, bits[5:1]};
							state_next = ST_TA;
						end
						else if (bits[8:5] == `RPM_OP_EXTWR)
						begin
							left_next  = bits[4:1];
							state_next = ST_ADDR;
						end
						// extended reads and other commands drop to idle here
					end
				ST_ADDR:
					if (cnt_reg == `RPM_FRAME_LAST)
					begin
						cnt_next = 4'h0;
						if (odd_ok({4'h0, bits[8:0]}))
						begin
							addr_next  = bits[8:1];
							state_next = ST_DATA;
						end
						else
						begin
							set[`RPM_F_ADDR_PAR] = 1'b1;
							state_next = ST_IDLE;
						end
					end
				ST_DATA:
					if (cnt_reg == `RPM_FRAME_LAST)
					begin
						cnt_next = 4'h0;
						if (!odd_ok({4'h0, bits[8:0]}))
						begin
							// stop here so the rest of a damaged sequence is never written
							set[`RPM_F_DATA_PAR] = 1'b1;
							state_next = ST_IDLE;
						end
						else
						begin
							wr_en = 1'b1;
							if (left_reg == 4'h0)
								state_next = ST_IDLE;
							else
							begin
								left_next = left_reg - 4'h1;
								// past the last address the bytes land nowhere
								addr_next = (addr_reg < `RPM_ADDR_LAST) ? addr_reg + 8'h01 : `RPM_ADDR_BEYOND;
							end
						end
					end
				ST_TA:
				begin
					cnt_next = 4'h0;
					if (addr_reg == `RPM_ADDR_STATUS)
					begin
						sh_next    = {4'h0, 1'b0, flag_reg, ~^flag_reg};
						state_next = ST_RD;
					end
					else
					begin
						set[`RPM_F_RD_UNUSED] = 1'b1;
						state_next = ST_IDLE;
					end
				end
				ST_RD:
				begin
					sh_next = {sh_reg[11:0], 1'b0};
					if (cnt_reg == `RPM_FRAME_LAST)
						state_next = ST_PARK;
				end
				ST_PARK:
				begin
					sdoe_next  = 1'b0;
					clr        = 1'b1;
					state_next = ST_IDLE;
				end
				default:
					cnt_next = 4'h0;
			endcase
		end
		else if (sclk_rise)
		begin
			// the slave drives read data and the park bit on rising edges
			if (state_reg == ST_RD)
			begin
				sdo_next  = sh_reg[8];
				sdoe_next = 1'b1;
			end
			else if (state_reg == ST_PARK)
				sdo_next = 1'b0;
		end
		if (wr_en)
		begin
			case (addr_reg)
				`RPM_ADDR_TURBO: turbo_next = wr_data;
				`RPM_ADDR_DAC_A: daca_next  = wr_data;
				`RPM_ADDR_DAC_B: dacb_next  = wr_data;
				`RPM_ADDR_POWER:
					if (wr_data[7:6] != `RPM_PS_RESERVED)
						pst_next = wr_data[7:6];
				default: set[`RPM_F_WR_UNUSED] = 1'b1;
			endcase
		end
		// a fresh fault in the clearing cycle survives the clear
		flag_next = (clr ? `RPM_RST_FLAGS : flag_reg) | set;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 13'h0000;
			addr_reg  <= `RPM_RST_BYTE;
			left_reg  <= 4'h0;
			flag_reg  <= `RPM_RST_FLAGS;
			arm_reg   <= 1'b0;
			sdo_reg   <= 1'b0;
			sdoe_reg  <= 1'b0;
			pst_reg   <= `RPM_PS_ACTIVE;
			turbo_reg <= `RPM_RST_BYTE;
			daca_reg  <= `RPM_RST_BYTE;
			dacb_reg  <= `RPM_RST_BYTE;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			addr_reg  <= addr_next;
			left_reg  <= left_next;
			flag_reg  <= flag_next;
			arm_reg   <= arm_next;
			sdo_reg   <= sdo_next;
			sdoe_reg  <= sdoe_next;
			pst_reg   <= pst_next;
			turbo_reg <= turbo_next;
			daca_reg  <= daca_next;
			dacb_reg  <= dacb_next;
		end
	end

	// enables decode from the held state; reserved code never gets stored
	assign POWER_STATE_O = pst_reg;
	assign BOOST_EN_O    = (pst_reg == `RPM_PS_ACTIVE) || (pst_reg == `RPM_PS_STARTUP);
	assign OUT_A_EN_O    = (pst_reg == `RPM_PS_ACTIVE);
	assign OUT_B_EN_O    = (pst_reg == `RPM_PS_ACTIVE);
	assign LOW_POWER_O   = (pst_reg == `RPM_PS_LOW);
	assign TURBO_O       = turbo_reg;
	assign DAC_A_O       = daca_reg;
	assign DAC_B_O       = dacb_reg;
	assign STATUS_O      = {1'b0, flag_reg};
	assign SDATA_O       = sdo_reg;
	assign SDATA_OE_O    = sdoe_reg;

	// checks on the decoded outputs and the frame sequencing
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	sequence s_cmd_done;
		sclk_fall && !ssc && state_reg == ST_CMD && cnt_reg == `RPM_CMD_LAST;
	endsequence
	sequence s_data_end;
		sclk_fall && !ssc && state_reg == ST_DATA && cnt_reg == `RPM_FRAME_LAST;
	endsequence
	sequence s_data_ok;
		s_data_end ##0 odd_ok({4'h0, bits[8:0]});
	endsequence

	a_power_write: assert property (wr_en && addr_reg == `RPM_ADDR_POWER && wr_data[7:6] != `RPM_PS_RESERVED
		|=> POWER_STATE_O == $past(wr_data[7:6])) else $error("power field not stored");
	a_active_outputs: assert property (POWER_STATE_O == `RPM_PS_ACTIVE
		|-> BOOST_EN_O && OUT_A_EN_O && OUT_B_EN_O && !LOW_POWER_O) else $error("active decode wrong");
	a_startup_outputs: assert property (POWER_STATE_O == `RPM_PS_STARTUP
		|-> BOOST_EN_O && !OUT_A_EN_O && !OUT_B_EN_O && !LOW_POWER_O) else $error("startup decode wrong");
	a_low_power: assert property (POWER_STATE_O == `RPM_PS_LOW
		|-> LOW_POWER_O && !BOOST_EN_O && !OUT_A_EN_O && !OUT_B_EN_O) else $error("low power decode wrong");
	a_reserved_keep: assert property (wr_en && addr_reg == `RPM_ADDR_POWER && wr_data[7:6] == `RPM_PS_RESERVED
		|=> $stable(POWER_STATE_O)) else $error("reserved code changed state");
	a_dac_a_store: assert property (s_data_ok ##0 addr_reg == `RPM_ADDR_DAC_A
		|=> DAC_A_O == $past(bits[8:1])) else $error("code A not loaded");
	a_read_msb: assert property (sclk_rise && state_reg == ST_RD && cnt_reg == 4'h0
		|=> SDATA_OE_O && !SDATA_O) else $error("status msb not zero");
	a_extrd_refused: assert property (s_cmd_done ##0 bits[8:5] == `RPM_OP_EXTRD
		|=> state_reg == ST_IDLE && !SDATA_OE_O) else $error("extended read answered");
	a_count_load: assert property (s_cmd_done ##0 (bits[12:9] == own_reg && odd_ok(bits) && bits[8:5] == `RPM_OP_EXTWR)
		|=> state_reg == ST_ADDR && left_reg == $past(bits[4:1])) else $error("byte count not taken");
	a_addr_step: assert property (s_data_ok ##0 (left_reg != 4'h0 && addr_reg < `RPM_ADDR_LAST)
		|=> addr_reg == $past(addr_reg) + 8'h01) else $error("address not incremented");
	a_data_parity: assert property (s_data_end ##0 !odd_ok({4'h0, bits[8:0]})
		|=> STATUS_O[`RPM_F_DATA_PAR] && state_reg == ST_IDLE) else $error("data parity not flagged");

endmodule : rpm_top

// ==== inc/rpm_defines.svh ====
// Purpose: constants of the front-end bus power-state and output-code slave
// Assumes: included by its bare name, once per compilation unit
// Notes:   addresses are bus register addresses, not byte addresses
`ifndef RPM_DEFINES_SVH
`define RPM_DEFINES_SVH
// register addresses
`define RPM_ADDR_TURBO    8'h01
`define RPM_ADDR_DAC_A    8'h02
`define RPM_ADDR_DAC_B    8'h03
`define RPM_ADDR_STATUS   8'h1A
`define RPM_ADDR_POWER    8'h1C
`define RPM_ADDR_LAST     8'h1F
`define RPM_ADDR_BEYOND   8'hFF
// power-state field codes and reset values
`define RPM_PS_ACTIVE     2'h0
`define RPM_PS_STARTUP    2'h1
`define RPM_PS_LOW        2'h2
`define RPM_PS_RESERVED   2'h3
`define RPM_RST_BYTE      8'h00
`define RPM_RST_FLAGS     7'h00
// command opcodes
`define RPM_OP_WRITE      3'h2
`define RPM_OP_READ       3'h3
`define RPM_OP_EXTWR      4'h0
`define RPM_OP_EXTRD      4'h2
// frame bit counts, as last bit index
`define RPM_CMD_LAST      4'hC
`define RPM_FRAME_LAST    4'h8
// status flag positions within the low seven bits
`define RPM_F_CMD_PAR     6
`define RPM_F_CMD_LEN     5
`define RPM_F_ADDR_PAR    4
`define RPM_F_DATA_PAR    3
`define RPM_F_RD_UNUSED   2
`define RPM_F_WR_UNUSED   1
`define RPM_F_BUS_ERR     0
`endif

// ==== inc/rpm_pkg.sv ====
// Purpose: types of the front-end bus power-state and output-code slave
// Assumes: nothing
// Notes:   constants live in rpm_defines.svh
package rpm_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_TA, ST_RD, ST_PARK} rpm_state_e;
	typedef logic [7:0] rpm_byte_t;
	typedef logic [1:0] rpm_pstate_t;
endpackage : rpm_pkg

// ==== testbench/rpm_bus_master.sv ====
// Purpose: bench model of the front-end bus master that issues command sequences
// Assumes: clk_i is the 40 MHz bench clock; one bus clock is 8 of its cycles (200 ns)
// Notes:   drives on bus clock rise, slave samples on fall; bus clock stands low between frames
`timescale 1ns/1ps

module rpm_bus_master (
	input  wire logic clk_i,
	input  wire logic sdata_i,
	output logic      sclk_o,
	output logic      sdata_o,
	output logic      sdata_oe_o
);
	// idle: clock low, data parked low and driven
	initial
	begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		sdata_oe_o = 1'b1;
	end

	// half a bus clock, changes land on falling edges of clk_i
	task automatic half();
		repeat (4) @(negedge clk_i);
	endtask : half

	// start condition: data rises then falls while the bus clock is low
	task automatic ssc();
		half();
		sdata_o = 1'b1;
		half();
		sdata_o = 1'b0;
		half();
	endtask : ssc

	task automatic put_bit(input logic b);
		sclk_o = 1'b1;
		sdata_o = b;
		half();
		sclk_o = 1'b0;
		half();
	endtask : put_bit

	// thirteen raw bits, msb first; lets the bench send a damaged command frame
	task automatic cmd_raw(input logic [12:0] v);
		for (int i = 12; i >= 0; i--)
			put_bit(v[i]);
	endtask : cmd_raw

	// command frame: address, command byte, odd parity, msb first
	task automatic cmd(input logic [3:0] addr, input logic [7:0] c);
		cmd_raw({addr, c, ~^{addr, c}});
	endtask : cmd

	// address or data frame; bad flips the parity bit on purpose
	task automatic frame(input logic [7:0] d, input logic bad);
		logic [8:0] v;
		v = {d, (~^d) ^ bad};
		for (int i = 8; i >= 0; i--)
			put_bit(v[i]);
	endtask : frame

	// park cycle, release, nine slave bits, slave park, then take the line back
	task automatic read_frame(output logic [8:0] v);
		put_bit(1'b0);
		sdata_oe_o = 1'b0;
		for (int i = 8; i >= 0; i--)
		begin
			sclk_o = 1'b1;
			half();
			sclk_o = 1'b0;
			repeat (3) @(negedge clk_i);
			v[i] = sdata_i; // sampled late in the low phase, after the slave's sync delay
			@(negedge clk_i);
		end
		sclk_o = 1'b1;
		half();
		sclk_o = 1'b0;
		half();
		sdata_oe_o = 1'b1;
	endtask : read_frame
endmodule : rpm_bus_master

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the power-state and output-code slave
// Assumes: slave address tied; line has a weak pull-down standing in for the bus keeper
// Notes:   every scenario waits fixed bus cycles; a watchdog bounds the whole run
`timescale 1ns/1ps
`include "rpm_defines.svh"

module tb_top;
	import rpm_pkg::*;
	localparam logic [3:0] SLV_ADDR = 4'h5; // arbitrary slave address
	logic        clk;
	logic        rst_n;
	logic        sclk, m_sd, m_oe, s_sd, s_oe, line, seen_oe;
	logic        boost, out_a, out_b, low_pw;
	rpm_pstate_t pstate;
	rpm_byte_t   turbo, dac_a, dac_b, status;
	logic [8:0]  rd;
	int          num_errors = 0;
	int          check_count = 0;

	// pull-down keeps a released line low, so no false start condition appears
	assign line = s_oe ? s_sd : (m_oe ? m_sd : 1'b0);

	always #12.5 clk = ~clk;

	always @(posedge clk)
		if (s_oe === 1'b1)
			seen_oe = 1'b1;

	rpm_bus_master i_master (.clk_i(clk), .sdata_i(line), .sclk_o(sclk), .sdata_o(m_sd), .sdata_oe_o(m_oe));

	rpm_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk), .SDATA_I(line), .SLAVE_ADDR_I(SLV_ADDR),
		.SDATA_O(s_sd), .SDATA_OE_O(s_oe), .POWER_STATE_O(pstate), .BOOST_EN_O(boost), .OUT_A_EN_O(out_a),
		.OUT_B_EN_O(out_b), .LOW_POWER_O(low_pw), .TURBO_O(turbo), .DAC_A_O(dac_a), .DAC_B_O(dac_b),
		.STATUS_O(status));

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// let the sync pipes carry the last bits through
	task automatic settle();
		repeat (8) @(negedge clk);
	endtask : settle

	task automatic test_reset();
		check(pstate, `RPM_PS_ACTIVE);
		check({boost, out_a, out_b, low_pw}, 4'hE);
		check(turbo | dac_a | dac_b, `RPM_RST_BYTE);
		check(status, 8'h00);
		$display("test reset done");
	endtask : test_reset

	task automatic test_ext_write();
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_EXTWR, 4'h2});
		i_master.frame(`RPM_ADDR_TURBO, 1'b0);
		i_master.frame(8'h5A, 1'b0);
		i_master.frame(8'hC3, 1'b0);
		i_master.frame(8'h7E, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(turbo, 8'h5A);
		check(dac_a, 8'hC3);
		check(dac_b, 8'h7E);
		check(status, 8'h00);
		$display("test extended write done");
	endtask : test_ext_write

	task automatic test_power();
		rpm_pstate_t code [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		rpm_pstate_t held [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
		logic [3:0]  ens [4] = '{4'h8, 4'h1, 4'h1, 4'hE};
		for (int i = 0; i < 4; i++)
		begin
			i_master.ssc();
			i_master.cmd(SLV_ADDR, {`RPM_OP_WRITE, 5'h1C});
			i_master.frame({code[i], 6'h00}, 1'b0);
			i_master.put_bit(1'b0);
			settle();
			check(pstate, held[i]);
			check({boost, out_a, out_b, low_pw}, ens[i]);
		end
		$display("test power states done");
	endtask : test_power

	task automatic read_cmd(input logic [7:0] c);
		seen_oe = 1'b0;
		i_master.ssc();
		i_master.cmd(SLV_ADDR, c);
		i_master.read_frame(rd);
		settle();
	endtask : read_cmd

	task automatic test_faults();
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_EXTWR, 4'h2});
		i_master.frame(`RPM_ADDR_TURBO, 1'b0);
		i_master.frame(8'h11, 1'b1);
		i_master.frame(8'h22, 1'b0);
		i_master.frame(8'h33, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(turbo, 8'h5A);
		check(dac_a, 8'hC3);
		check(dac_b, 8'h7E);
		check(status, 8'h08);
		read_cmd({`RPM_OP_READ, 5'h1A});
		check(rd, {8'h08, 1'b0});
		check(status, 8'h00);
		read_cmd({`RPM_OP_READ, 5'h01});
		check(seen_oe, 1'b0);
		check(status, 8'h04);
		read_cmd({`RPM_OP_READ, 5'h1A});
		check(rd, {8'h04, 1'b0});
		read_cmd({`RPM_OP_EXTRD, 4'h0});
		check(seen_oe, 1'b0);
		check(status, 8'h00);
		$display("test faults and read-back done");
	endtask : test_faults

	// every remaining flag in turn: bad command parity, bad address parity, unused write, two cut frames
	task automatic test_flags();
		i_master.ssc();
		i_master.cmd_raw({SLV_ADDR, `RPM_OP_WRITE, 5'h1C, ^{SLV_ADDR, `RPM_OP_WRITE, 5'h1C}});
		i_master.frame(8'h40, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(pstate, `RPM_PS_ACTIVE);
		check(status, 8'h40);
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_EXTWR, 4'h0});
		i_master.frame(`RPM_ADDR_TURBO, 1'b1);
		i_master.frame(8'hA5, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(turbo, 8'h5A);
		check(status, 8'h50);
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_WRITE, 5'h05});
		i_master.frame(8'h12, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(status, 8'h52);
		// data is left low before each start, else the start edge would be lost
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_WRITE, 5'h1C});
		i_master.put_bit(1'b0);
		i_master.put_bit(1'b0);
		i_master.ssc();
		i_master.put_bit(1'b0);
		i_master.ssc();
		i_master.cmd(SLV_ADDR, {`RPM_OP_WRITE, 5'h1C});
		i_master.frame(8'h80, 1'b0);
		i_master.put_bit(1'b0);
		settle();
		check(pstate, `RPM_PS_LOW);
		check(status, 8'h73);
		read_cmd({`RPM_OP_READ, 5'h1A});
		check(rd, {8'h73, 1'b0});
		check(seen_oe, 1'b1);
		check(status, 8'h00);
		$display("test status flags done");
	endtask : test_flags

	// a reset in mid-run, from the low-power state, brings back every default
	task automatic test_reset_again();
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		$display("test reset in mid-run done");
	endtask : test_reset_again

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// watchdog: a run that outlives its bound counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		seen_oe = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		test_ext_write();
		test_power();
		test_faults();
		test_flags();
		test_reset_again();
		end_of_test();
	end
endmodule : tb_top
